// ==== hdl/pss_defines.svh ====
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Register byte offsets on the AHB-Lite slave
`define PSS_OFS_CTRL        8'h00
`define PSS_OFS_REF         8'h04
`define PSS_OFS_MAIN        8'h08
`define PSS_OFS_STATUS      8'h0C

// Control register fields
`define PSS_CTRL_SETTLE_LSB 0
`define PSS_CTRL_SETTLE_MSB 15
`define PSS_CTRL_SOFT_SAVE  16
`define PSS_SETTLE_RST      16'h0100

// Shift register layout, bit 0 is the last bit shifted in
`define PSS_SR_WIDTH        20
`define PSS_SR_DEST_BIT     0
`define PSS_REF_LSB         1
`define PSS_REF_MSB         17
`define PSS_MAIN_LSB        1
`define PSS_MAIN_MSB        19

// Latch reset values
`define PSS_REF_COUNT_RST   14'h0003
`define PSS_MAIN_COUNT_RST  11'h003
`define PSS_SWALLOW_RST     7'h00

// Timing
`define PSS_CLK_NS          40
`define PSS_LOCK_NS         120
`define PSS_LOCK_CYC        (`PSS_LOCK_NS / `PSS_CLK_NS)
`define PSS_LIMIT_NS        80
`define PSS_LIMIT_CYC       (`PSS_LIMIT_NS / `PSS_CLK_NS)

`endif

// ==== hdl/pss_pkg.sv ====
`default_nettype none
package pss_pkg;

   typedef struct packed
   {
      logic        monitor_select;
      logic        phase_polarity_select;
      logic        prescaler_ratio_select;
      logic [13:0] ref_count;
   } pss_ref_t;

   typedef struct packed
   {
      logic        pump_current_select;
      logic [10:0] main_count;
      logic [6:0]  swallow_count;
   } pss_main_t;

   typedef struct packed
   {
      logic drive;
      logic drive_oe;
      logic high_current;
   } pss_pump_t;

   typedef struct packed
   {
      logic level;
      logic oe;
   } pss_od_t;

   typedef enum logic [1:0]
   {
      PWR_SAVE,
      PWR_SETTLE,
      PWR_RUN
   } pss_pwr_t;

endpackage
`default_nettype wire

// ==== hdl/pss_sync.sv ====
`default_nettype none
module pss_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             i_clock,
   input  wire logic             i_rstn,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   genvar g;

   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic meta_ff;
         logic sync_ff;
         always_ff @(posedge i_clock)
         begin
            if (!i_rstn)
            begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end
            else
            begin
               meta_ff <= i_async[g];
               sync_ff <= meta_ff;
            end
         end
         assign o_sync[g] = sync_ff;
      end
   endgenerate

endmodule
`default_nettype wire

// ==== hdl/pss_core.sv ====
// Functional notes
// - Each serial clock rising edge shifts one data bit in.
// - Strobe rise latches word: destination high to reference, low to main.
// - Reference count is 14-bit binary, 3 to 16383; host never loads below 3.
// - Main count is 11-bit binary, 3 to 2047; host never loads below 3.
// - Swallow count is 7-bit binary, accepted over 0 to 127.
// - Prescaler select high gives 64/65, low gives 128/129.
// - Pump current select high gives 6.0 mA, low gives 1.5 mA.
// - Monitor select high routes frequency monitor, low routes lock.
// - Polarity high: reference lead drives pump high, lag drives it low.
// - Polarity low: roles swap, reference lead drives pump low.
// - Monitor carries divided reference if polarity high, divided VCO if low.
// - Pump output enable low forces pump output to high impedance.
// - Power save low enters low power with pump output high impedance.
// - Lock indicator stays high during power saving.
// - Power save high returns the device to normal operation; here only with CTRL soft save bit 16 clear, after the settle count.
// - After power save exit, phase error output magnitude is limited.
// - VCO division is prescaler modulus times main count plus swallow count.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`include "pss_defines.svh"
`default_nettype none
module pss_core
(
   input  wire logic             i_clock,
   input  wire logic             i_rstn,
   input  wire logic             i_sdata,
   input  wire logic             i_sclk,
   input  wire logic             i_load_strobe,
   input  wire logic             i_power_save_n,
   input  wire logic             i_pump_output_enable,
   input  wire logic             i_ref_tick,
   input  wire logic             i_vco_tick,
   input  wire logic             i_hsel,
   input  wire logic [31:0]      i_haddr,
   input  wire logic [1:0]       i_htrans,
   input  wire logic             i_hwrite,
   input  wire logic [2:0]       i_hsize,
   input  wire logic [31:0]      i_hwdata,
   input  wire logic             i_hready,
   output logic      [31:0]      o_hrdata,
   output logic                  o_hreadyout,
   output logic                  o_hresp,
   output pss_pkg::pss_pump_t    o_pump,
   output logic                  o_phase_ref,
   output pss_pkg::pss_od_t      o_phase_vco,
   output logic                  o_monitor,
   output logic                  o_prescaler_ratio_select,
   output logic                  o_power_save
);
   import pss_pkg::*;

   logic [4:0]                   pin_sync;
   logic                         sdata_s;
   logic                         sclk_s;
   logic                         strobe_s;
   logic                         power_save_n_s;
   logic                         pump_en_s;
   logic                         sclk_d_ff;
   logic                         strobe_d_ff;
   logic                         sclk_rise;
   logic                         strobe_rise;
   logic [`PSS_SR_WIDTH-1:0]     shift_ff;
   pss_ref_t                     ref_ff;
   pss_main_t                    main_ff;
   logic [16:0]                  ctrl_ff;
   pss_pwr_t                     pwr_ff;
   pss_pwr_t                     nxt_pwr;
   logic [15:0]                  settle_ff;
   logic                         save_request;
   logic                         dividers_run;
   logic [13:0]                  ref_cnt_ff;
   logic [17:0]                  vco_cnt_ff;
   logic [17:0]                  vco_total;
   logic [17:0]                  vco_last;
   logic                         ref_pulse_ff;
   logic                         vco_pulse_ff;
   logic                         ref_tog_ff;
   logic                         vco_tog_ff;
   logic                         up_ff;
   logic                         dn_ff;
   logic                         nxt_up;
   logic                         nxt_dn;
   logic [7:0]                   pw_cnt_ff;
   logic                         lock_ff;
   logic                         lead;
   logic                         lag;
   logic                         limited;
   logic                         pump_allowed;
   logic                         addr_ok;
   logic                         wr_pend_ff;
   logic [7:0]                   wr_addr_ff;
   logic [31:0]                  hrdata_ff;
   logic [16:0]                  ctrl_view;

   pss_sync
   #(
      .WIDTH (5)
   )
   u_pin_sync
   (
      .i_clock (i_clock),
      .i_rstn  (i_rstn),
      .i_async ({i_sdata, i_sclk, i_load_strobe, i_power_save_n,
                 i_pump_output_enable}),
      .o_sync  (pin_sync)
   );

   assign sdata_s        = pin_sync[4];
   assign sclk_s         = pin_sync[3];
   assign strobe_s       = pin_sync[2];
   assign power_save_n_s = pin_sync[1];
   assign pump_en_s      = pin_sync[0];

   // Edge detection on the synchronised serial pins
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         sclk_d_ff   <= 1'b0;
         strobe_d_ff <= 1'b0;
      end
      else
      begin
         sclk_d_ff   <= sclk_s;
         strobe_d_ff <= strobe_s;
      end
   end

   assign sclk_rise   = sclk_s & ~sclk_d_ff;
   assign strobe_rise = strobe_s & ~strobe_d_ff;

   // Serial shift register, newest bit at bit 0
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         shift_ff <= '0;
      end
      else if (sclk_rise)
      begin
         shift_ff <= {shift_ff[`PSS_SR_WIDTH-2:0], sdata_s};
      end
   end

   // Divider and configuration latches
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         ref_ff.monitor_select         <= 1'b0;
         ref_ff.phase_polarity_select  <= 1'b0;
         ref_ff.prescaler_ratio_select <= 1'b0;
         ref_ff.ref_count              <= `PSS_REF_COUNT_RST;
         main_ff.pump_current_select   <= 1'b0;
         main_ff.main_count            <= `PSS_MAIN_COUNT_RST;
         main_ff.swallow_count         <= `PSS_SWALLOW_RST;
      end
      else if (strobe_rise)
      begin
         if (shift_ff[`PSS_SR_DEST_BIT])
         begin
            ref_ff <= pss_ref_t'(shift_ff[`PSS_REF_MSB:`PSS_REF_LSB]);
         end
         else
         begin
            main_ff <= pss_main_t'(shift_ff[`PSS_MAIN_MSB:`PSS_MAIN_LSB]);
         end
      end
   end

   // Power saving sequence
   assign save_request = ~power_save_n_s | ctrl_ff[`PSS_CTRL_SOFT_SAVE];

   always_comb
   begin
      nxt_pwr = pwr_ff;
      case (pwr_ff)
         PWR_SAVE:
         begin
            if (!save_request)
            begin
               nxt_pwr = PWR_SETTLE;
            end
         end
         PWR_SETTLE:
         begin
            if (save_request)
            begin
               nxt_pwr = PWR_SAVE;
            end
            else if (settle_ff == 16'h0000)
            begin
               nxt_pwr = PWR_RUN;
            end
         end
         PWR_RUN:
         begin
            if (save_request)
            begin
               nxt_pwr = PWR_SAVE;
            end
         end
         default:
         begin
            nxt_pwr = PWR_SAVE;
         end
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         pwr_ff <= PWR_SAVE;
      end
      else
      begin
         pwr_ff <= nxt_pwr;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         settle_ff <= 16'h0000;
      end
      else if (pwr_ff == PWR_SAVE)
      begin
         settle_ff <= ctrl_ff[`PSS_CTRL_SETTLE_MSB:`PSS_CTRL_SETTLE_LSB];
      end
      else if (pwr_ff == PWR_SETTLE && settle_ff != 16'h0000)
      begin
         settle_ff <= settle_ff - 16'h0001;
      end
   end

   assign dividers_run = (pwr_ff != PWR_SAVE);

   // Pulse swallow division ratio
   assign vco_total = (ref_ff.prescaler_ratio_select ?
                       {1'b0, main_ff.main_count, 6'h00} :
                       {main_ff.main_count, 7'h00})
                      + {11'h000, main_ff.swallow_count};
   assign vco_last  = vco_total - 18'h00001;

   // Dividers restart together when power saving ends
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn || !dividers_run)
      begin
         ref_cnt_ff   <= 14'h0000;
         ref_pulse_ff <= 1'b0;
      end
      else if (i_ref_tick)
      begin
         if (ref_cnt_ff >= ref_ff.ref_count - 14'h0001)
         begin
            ref_cnt_ff   <= 14'h0000;
            ref_pulse_ff <= 1'b1;
         end
         else
         begin
            ref_cnt_ff   <= ref_cnt_ff + 14'h0001;
            ref_pulse_ff <= 1'b0;
         end
      end
      else
      begin
         ref_pulse_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn || !dividers_run)
      begin
         vco_cnt_ff   <= 18'h00000;
         vco_pulse_ff <= 1'b0;
      end
      else if (i_vco_tick)
      begin
         if (vco_cnt_ff >= vco_last)
         begin
            vco_cnt_ff   <= 18'h00000;
            vco_pulse_ff <= 1'b1;
         end
         else
         begin
            vco_cnt_ff   <= vco_cnt_ff + 18'h00001;
            vco_pulse_ff <= 1'b0;
         end
      end
      else
      begin
         vco_pulse_ff <= 1'b0;
      end
   end

   // Square wave copies of the divided rates for the monitor pin
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         ref_tog_ff <= 1'b0;
         vco_tog_ff <= 1'b0;
      end
      else
      begin
         ref_tog_ff <= ref_tog_ff ^ ref_pulse_ff;
         vco_tog_ff <= vco_tog_ff ^ vco_pulse_ff;
      end
   end

   // Phase frequency detector
   assign nxt_up = (up_ff | ref_pulse_ff) & ~(dn_ff | vco_pulse_ff);
   assign nxt_dn = (dn_ff | vco_pulse_ff) & ~(up_ff | ref_pulse_ff);

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn || !dividers_run)
      begin
         up_ff <= 1'b0;
         dn_ff <= 1'b0;
      end
      else
      begin
         up_ff <= nxt_up;
         dn_ff <= nxt_dn;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn || !(up_ff | dn_ff))
      begin
         pw_cnt_ff <= 8'h00;
      end
      else if (pw_cnt_ff != 8'hFF)
      begin
         pw_cnt_ff <= pw_cnt_ff + 8'h01;
      end
   end

   // Lock holds while error pulses stay short
   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         lock_ff <= 1'b0;
      end
      else if (!dividers_run)
      begin
         lock_ff <= 1'b1;
      end
      else if ((up_ff | dn_ff) && pw_cnt_ff > 8'(`PSS_LOCK_CYC))
      begin
         lock_ff <= 1'b0;
      end
      else if ((up_ff | dn_ff) && !(nxt_up | nxt_dn))
      begin
         lock_ff <= 1'b1;
      end
   end

   // Polarity maps detector state onto lead and lag
   assign lead = ref_ff.phase_polarity_select ? up_ff : dn_ff;
   assign lag  = ref_ff.phase_polarity_select ? dn_ff : up_ff;

   // Error pulses are clipped while settling after power save
   assign limited = (pwr_ff == PWR_SETTLE) &&
                    (pw_cnt_ff >= 8'(`PSS_LIMIT_CYC));

   assign pump_allowed = pump_en_s && (pwr_ff != PWR_SAVE) &&
                         !limited;

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         o_pump                   <= '0;
         o_phase_ref              <= 1'b0;
         o_phase_vco              <= '0;
         o_monitor                <= 1'b0;
         o_prescaler_ratio_select <= 1'b0;
         o_power_save             <= 1'b1;
      end
      else
      begin
         o_pump.drive        <= lead;
         o_pump.drive_oe     <= (lead | lag) & pump_allowed;
         o_pump.high_current <= main_ff.pump_current_select;
         o_phase_ref         <= lag;
         o_phase_vco.level   <= 1'b0;
         o_phase_vco.oe      <= lead;
         if (ref_ff.monitor_select)
         begin
            o_monitor <= ref_ff.phase_polarity_select ?
                         ref_tog_ff : vco_tog_ff;
         end
         else
         begin
            o_monitor <= lock_ff;
         end
         o_prescaler_ratio_select <= ref_ff.prescaler_ratio_select;
         o_power_save             <= (pwr_ff == PWR_SAVE);
      end
   end

   // AHB-Lite slave, zero wait states
   function automatic logic [31:0] read_word
   (
      input logic [7:0]  addr,
      input logic [16:0] ctrl
   );
      logic [31:0] word;
      word = 32'h0000_0000;
      if (addr == `PSS_OFS_CTRL)
      begin
         word = {15'h0000, ctrl};
      end
      else if (addr == `PSS_OFS_REF)
      begin
         word = {15'h0000, ref_ff};
      end
      else if (addr == `PSS_OFS_MAIN)
      begin
         word = {13'h0000, main_ff};
      end
      else if (addr == `PSS_OFS_STATUS)
      begin
         word = {26'h0000000, pwr_ff, lock_ff, up_ff, dn_ff,
                 save_request};
      end
      return word;
   endfunction

   assign addr_ok = i_hsel && i_htrans[1] && i_hready &&
                    (i_haddr[31:8] == 24'h000000);

   assign ctrl_view = (wr_pend_ff && wr_addr_ff == `PSS_OFS_CTRL) ?
                      i_hwdata[16:0] : ctrl_ff;

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end
      else
      begin
         wr_pend_ff <= addr_ok && i_hwrite;
         wr_addr_ff <= i_haddr[7:0];
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         ctrl_ff <= {1'b0, `PSS_SETTLE_RST};
      end
      else if (wr_pend_ff && wr_addr_ff == `PSS_OFS_CTRL)
      begin
         ctrl_ff <= i_hwdata[16:0];
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         hrdata_ff <= 32'h0000_0000;
      end
      else if (addr_ok && !i_hwrite)
      begin
         hrdata_ff <= read_word(i_haddr[7:0], ctrl_view);
      end
   end

   assign o_hrdata    = hrdata_ff;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

endmodule
`default_nettype wire

// ==== sim/pss_core_chk.sv ====
`default_nettype none
module pss_core_chk
(
   input wire logic               i_clock,
   input wire logic               i_rstn,
   input wire logic               i_power_save_n,
   input wire logic               i_pump_output_enable,
   input wire logic               i_load_strobe,
   input wire logic               i_hsel,
   input wire logic [1:0]         i_htrans,
   input wire logic               i_hready,
   input wire logic               i_hwrite,
   input wire logic [31:0]        o_hrdata,
   input wire logic               o_hreadyout,
   input wire pss_pkg::pss_pump_t o_pump,
   input wire logic               o_phase_ref,
   input wire pss_pkg::pss_od_t   o_phase_vco,
   input wire logic               o_prescaler_ratio_select,
   input wire logic               o_power_save
);
   timeunit 1ns;
   timeprecision 1ps;
   import pss_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   sequence s_en_low;
      !i_pump_output_enable [*6];
   endsequence
   sequence s_long_pulse;
      o_pump.drive_oe [*3];
   endsequence
   AST_READY: assert property (o_hreadyout)
      else $error("hreadyout dropped");
   AST_HRDATA: assert property
      (!(i_hsel && i_htrans[1] && i_hready && !i_hwrite) |=> $stable(o_hrdata))
      else $error("read data changed without a read");
   AST_SAVE_ENTER: assert property
      ($fell(i_power_save_n) |-> ##[1:6] o_power_save)
      else $error("power save not entered");
   AST_SAVE_HIZ: assert property
      (o_power_save && $past(o_power_save) |-> !o_pump.drive_oe)
      else $error("pump driven in power save");
   AST_PUMP_EN_LOW: assert property (s_en_low |-> !o_pump.drive_oe)
      else $error("pump driven while disabled");
   AST_STROBE_HOLD: assert property (!i_load_strobe [*8] |=>
      $stable(o_prescaler_ratio_select) && $stable(o_pump.high_current))
      else $error("settings changed without a strobe");
   AST_SETTLE: assert property ($fell(o_power_save) |-> not (##[1:200] s_long_pulse))
      else $error("error pulse not limited after power save");
   AST_LEAD_EXCL: assert property (o_pump.drive |-> !o_phase_ref)
      else $error("pump and reference comparator both high");
   AST_VCO_LEAD: assert property (o_phase_vco.oe == o_pump.drive)
      else $error("comparator pull-down disagrees with pump");
   AST_OD_LEVEL: assert property (!o_phase_vco.level)
      else $error("open-drain output driven high");
endmodule
bind pss_core pss_core_chk i_pss_core_chk
(
   .i_clock(i_clock), .i_rstn(i_rstn), .i_power_save_n(i_power_save_n),
   .i_pump_output_enable(i_pump_output_enable), .i_hsel(i_hsel),
   .i_load_strobe(i_load_strobe), .i_htrans(i_htrans), .i_hready(i_hready),
   .i_hwrite(i_hwrite), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
   .o_pump(o_pump), .o_phase_ref(o_phase_ref), .o_phase_vco(o_phase_vco),
   .o_prescaler_ratio_select(o_prescaler_ratio_select),
   .o_power_save(o_power_save)
);
`default_nettype wire

// ==== sim/pss_host.sv ====
`default_nettype none
module pss_host
(
   input  wire logic i_clock,
   output var  logic o_sdata,
   output var  logic o_sclk,
   output var  logic o_load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_sdata = 1'h0;
      o_sclk = 1'h0;
      o_load_strobe = 1'h0;
   end
   // Serial clock stands low between frames; released data is inverted
   task automatic send(input logic [19:0] w, input logic stb);
      @(posedge i_clock);
      for (int i = 19; i >= 0; i--)
      begin
         o_sclk <= 1'h0;
         o_sdata <= w[i];
         repeat (4) @(posedge i_clock);
         o_sclk <= 1'h1;
         repeat (4) @(posedge i_clock);
      end
      o_sclk <= 1'h0;
      o_sdata <= ~w[0];
      repeat (4) @(posedge i_clock);
      o_load_strobe <= stb;
      repeat (4) @(posedge i_clock);
      o_load_strobe <= 1'h0;
      repeat (4) @(posedge i_clock);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_pss_core.sv ====
`include "pss_defines.svh"
`default_nettype none
module tb_pss_core;
   timeunit 1ns;
   timeprecision 1ps;
   import pss_pkg::*;
   localparam logic [31:0] CT = `PSS_OFS_CTRL;
   localparam logic [31:0] RF = `PSS_OFS_REF;
   localparam logic [31:0] MN = `PSS_OFS_MAIN;
   localparam logic [31:0] ST = `PSS_OFS_STATUS;
   logic        i_clock  = 1'h0;
   logic        i_rstn   = 1'h0;
   logic        save_n   = 1'h0;
   logic        pump_en  = 1'h1;
   logic        ref_tick = 1'h0;
   logic        vco_tick = 1'h0;
   logic        hsel     = 1'h0;
   logic        hwrite   = 1'h0;
   logic [1:0]  htrans   = 2'h0;
   logic [31:0] haddr    = 32'h0;
   logic [31:0] hwdata   = 32'h0;
   logic [31:0] hrdata, rd;
   logic        sdata, sclk, strobe, hreadyout, hresp;
   logic        phase_ref, monitor, prs, pwr_save;
   pss_pump_t   pump;
   pss_od_t     phase_vco;
   int          n_fail = 0;
   int          total_checks = 0;
   int          c_drv, c_ref, c_oe, c_mon;
   pss_core i_pss_core
   (
      .i_clock(i_clock), .i_rstn(i_rstn), .i_sdata(sdata), .i_sclk(sclk),
      .i_load_strobe(strobe), .i_power_save_n(save_n),
      .i_pump_output_enable(pump_en), .i_ref_tick(ref_tick),
      .i_vco_tick(vco_tick), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .o_pump(pump),
      .o_phase_ref(phase_ref), .o_phase_vco(phase_vco), .o_monitor(monitor),
      .o_prescaler_ratio_select(prs), .o_power_save(pwr_save)
   );
   pss_host i_pss_host
   (
      .i_clock(i_clock), .o_sdata(sdata), .o_sclk(sclk),
      .o_load_strobe(strobe)
   );
   initial
   begin
      forever #20 i_clock = ~i_clock;
   end
   always @(posedge i_clock)
   begin
      ref_tick <= ~ref_tick;
      vco_tick <= ~vco_tick;
   end
   task automatic wrap_up;
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
      @(posedge i_clock);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge i_clock); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_clock); while (hreadyout !== 1'h1);
      r = hrdata;
   endtask
   task automatic rdc(input string nm, input logic [31:0] a, exp);
      ahb(1'h0, a, 32'h0, rd);
      chk(nm, exp, rd);
   endtask
   task automatic load(input logic [19:0] w, input logic stb,
                       input logic [31:0] a, exp);
      i_pss_host.send(w, stb);
      repeat (8) @(posedge i_clock);
      rdc("latch", a, exp);
   endtask
   // Counts pump lead, reference lag, pump enable and monitor toggles
   task automatic measure(input int n);
      logic last;
      c_drv = 0;
      c_ref = 0;
      c_oe = 0;
      c_mon = 0;
      last = monitor;
      repeat (n)
      begin
         @(posedge i_clock);
         c_drv += (pump.drive === 1'h1);
         c_ref += (phase_ref === 1'h1);
         c_oe += (pump.drive_oe === 1'h1);
         c_mon += (monitor !== last);
         last = monitor;
      end
   endtask
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_rstn <= 1'h1;
      @(posedge i_clock);
      chk("power_save", 32'h1, pwr_save);
      rdc("ctrl", CT, 32'h0100);
      rdc("ref", RF, 32'h0003);
      rdc("main", MN, 32'h0180);
      ahb(1'h1, CT, 32'h0ABC, rd);
      ahb(1'h1, RF, 32'h1234, rd);
      ahb(1'h1, 32'h10, 32'hFFFF_FFFF, rd);
      rdc("ctrl", CT, 32'h0ABC);
      rdc("ref", RF, 32'h0003);
      rdc("unmapped", 32'h10, 32'h0);
      chk("hresp", 32'h0, hresp);
      chk("lock_in_save", 32'h1, monitor);
      chk("pump_oe_save", 32'h0, pump.drive_oe);
      load({2'h2, 3'h3, 14'h3FFF, 1'h1}, 1'h1, RF, 32'hFFFF);
      chk("prescaler", 32'h1, prs);
      load({1'h1, 11'h7FF, 7'h7F, 1'h0}, 1'h1, MN, 32'h7FFFF);
      chk("current", 32'h1, pump.high_current);
      rdc("ref", RF, 32'hFFFF);
      load({1'h0, 11'h003, 7'h00, 1'h0}, 1'h0, MN, 32'h7FFFF);
      load({1'h0, 11'h003, 7'h00, 1'h0}, 1'h1, MN, 32'h0180);
      chk("current", 32'h0, pump.high_current);
      load({2'h0, 3'h7, 14'h0003, 1'h1}, 1'h1, RF, 32'h1C003);
      ahb(1'h1, CT, 32'h0001_0ABC, rd);
      save_n <= 1'h1;
      repeat (8) @(posedge i_clock);
      ahb(1'h0, ST, 32'h0, rd);
      chk("status_save", 32'h01, rd & 32'h31);
      ahb(1'h1, CT, 32'h0ABC, rd);
      repeat (8) @(posedge i_clock);
      chk("power_save", 32'h0, pwr_save);
      repeat (2800) @(posedge i_clock);
      ahb(1'h0, ST, 32'h0, rd);
      chk("status_run", 32'h20, rd & 32'h30);
      measure(402);
      chk("lead_drive", 32'h1, c_drv > c_ref);
      chk("ref_monitor", 32'h43, c_mon);
      chk("pump_oe_on", 32'h1, c_oe > 0);
      pump_en <= 1'h0;
      repeat (10) @(posedge i_clock);
      measure(100);
      chk("pump_oe_off", 32'h0, c_oe);
      pump_en <= 1'h1;
      load({2'h1, 3'h4, 14'h0003, 1'h1}, 1'h1, RF, 32'h10003);
      chk("prescaler", 32'h0, prs);
      measure(1536);
      chk("lag_ref", 32'h1, c_ref > c_drv);
      chk("vco_monitor", 32'h2, c_mon);
      save_n <= 1'h0;
      repeat (8) @(posedge i_clock);
      chk("power_save", 32'h1, pwr_save);
      i_rstn <= 1'h0;
      save_n <= 1'h1;
      repeat (4) @(posedge i_clock);
      i_rstn <= 1'h1;
      @(posedge i_clock);
      chk("power_save", 32'h1, pwr_save);
      rdc("ctrl", CT, 32'h0100);
      rdc("ref", RF, 32'h0003);
      wrap_up;
   end
   initial
   begin
      #800000;
      n_fail++;
      wrap_up;
   end
endmodule
`default_nettype wire
